/* flash_seq_cfg.svh */
// Offsets, field positions, reset values and counts of the flash sequencer.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH

// Register offsets on the 4-bit register port
`define OFF_CONFIG       4'h0
`define OFF_FAULT_CONFIG 4'h1
`define OFF_STATUS       4'h2
`define OFF_FAULT_STATUS 4'h3
`define OFF_SECURITY     4'h4
`define OFF_PARAM_INDEX  4'h5
`define OFF_PARAM_WORD   4'h6
`define OFF_PROTECTION   4'h7

// Field positions
`define BIT_CMD_COMPLETE_IRQ_EN     7
`define BIT_DOUBLE_FAULT_IRQ_EN    1
`define BIT_SINGLE_FAULT_IRQ_EN    0
`define BIT_CMD_COMPLETE_FLAG     7
`define BIT_ACCESS_ERROR_FLAG   5
`define BIT_PROTECTION_VIOLATION_FLAG   4
`define BIT_MGHI     1
`define BIT_MGLO     0
`define BIT_DOUBLE_FAULT_FLAG    1
`define BIT_SINGLE_FAULT_FLAG    0
`define BIT_PROT_EN  7

// Command codes and security encodings
`define CMD_ERASE_SECTOR 8'h12
`define CMD_VERIFY_ALL   8'h01
`define CMD_VERIFY_KEY   8'h0C
`define SEC_UNSECURED    2'h2
`define BACKDOOR_KEY_ENABLE_ENABLED    2'h2
`define KEY_ALL_ZERO     16'h0000
`define KEY_ALL_ONE      16'hFFFF

// Reset values
`define SEC_RESET        8'hFF
`define PROT_RESET       8'h00

// Init counter value that ends the reset initialization sequence, one less than its cycles
`define INIT_CYCLES      8'h10

`endif

/* flash_seq_pkg.sv */
// Types shared by the flash sequencer modules.
// Assumes nothing of its surroundings.
package flash_seq_pkg;

	typedef enum logic [2:0] {
		ST_INIT,
		ST_IDLE,
		ST_ERASE,
		ST_VERIFY,
		ST_KEY,
		ST_VALL
	} seq_state_e;

	typedef enum logic [1:0] {
		KS_IDLE,
		KS_COMPARE,
		KS_DONE
	} key_state_e;

endpackage : flash_seq_pkg

/* key_check_if.sv */
// Carrier between the sequencer and the backdoor key checker.
// Assumes both ends share one clock.
interface key_check_if;
	logic        start;
	logic [63:0] presented;
	logic [63:0] stored;
	logic        busy;
	logic        done;
	logic        match;
	logic        locked;

	modport ctrl (
		output start, presented, stored,
		input  busy, done, match, locked
	);
	modport chk (
		input  start, presented, stored,
		output busy, done, match, locked
	);
endinterface : key_check_if

/* key_check.sv */
// Backdoor key comparison, one 16-bit key per cycle.
// Assumes start is a one-cycle pulse issued only while not busy or locked.
`include "flash_seq_cfg.svh"

module key_check (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Sequencer side
	key_check_if.chk kc
);

	flash_seq_pkg::key_state_e stateReg, stateNext;
	logic [1:0]                idxReg, idxNext;
	logic                      matchReg, matchNext;
	logic                      lockReg, lockNext;
	logic [15:0]               keyP;
	logic [15:0]               keyS;
	logic                      keyOk;

	assign keyP = kc.presented[{idxReg, 4'h0} +: 16];
	assign keyS = kc.stored[{idxReg, 4'h0} +: 16];
	// Blank-looking keys never unlock, whatever is stored
	assign keyOk = (keyP == keyS) && (keyS != `KEY_ALL_ZERO)
		&& (keyS != `KEY_ALL_ONE);

	always_comb begin
		stateNext = stateReg;
		idxNext   = idxReg;
		matchNext = matchReg;
		lockNext  = lockReg;
		unique case (stateReg)
			flash_seq_pkg::KS_IDLE: begin
				if (kc.start) begin
					stateNext = flash_seq_pkg::KS_COMPARE;
					idxNext   = 2'h0;
					matchNext = 1'b1;
				end
			end
			flash_seq_pkg::KS_COMPARE: begin
				matchNext = matchReg && keyOk;
				idxNext   = idxReg + 2'h1;
				if (idxReg == 2'h3) begin
					stateNext = flash_seq_pkg::KS_DONE;
				end
			end
			flash_seq_pkg::KS_DONE: begin
				stateNext = flash_seq_pkg::KS_IDLE;
				// Only a reset lifts the lock
				if (!matchReg) begin
					lockNext = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			stateReg <= flash_seq_pkg::KS_IDLE;
			idxReg   <= 2'h0;
			matchReg <= 1'b0;
			lockReg  <= 1'b0;
		end else begin
			stateReg <= stateNext;
			idxReg   <= idxNext;
			matchReg <= matchNext;
			lockReg  <= lockNext;
		end
	end

	assign kc.busy   = (stateReg != flash_seq_pkg::KS_IDLE);
	assign kc.done   = (stateReg == flash_seq_pkg::KS_DONE);
	assign kc.match  = matchReg;
	assign kc.locked = lockReg;

endmodule : key_check

/* erase_check.sv */
// Launch checks of the sector erase command, purely combinational.
// Assumes parameter words are stable during the launch cycle.
module erase_check #(
	parameter logic [1:0]  EE_HI       = 2'h0,
	parameter logic [15:0] EE_BASE     = 16'h0400,
	parameter logic [15:0] EE_SIZE     = 16'h0400,
	parameter int          SECTOR_BITS = 2
) (
	// Command parameters
	input  wire logic [2:0]  paramIndex,
	input  wire logic [15:0] cmdWord,
	input  wire logic [15:0] addrWord,
	// Mode and protection
	input  wire logic        modeOk,
	input  wire logic        protEnable,
	input  wire logic [6:0]  protSectors,
	// Results
	output logic             access_error_flag,
	output logic             protErr
);

	logic [15:0] offset;
	logic [15:0] sector;
	logic [16:0] addrEnd;
	logic        addrBad;

	assign offset  = addrWord - EE_BASE;
	// Whole offset kept, so a far sector never wraps into a low one
	assign sector  = offset >> SECTOR_BITS;
	assign addrEnd = {1'b0, EE_BASE} + {1'b0, EE_SIZE};
	assign addrBad = (cmdWord[7:0] != {6'h00, EE_HI})
		|| (addrWord < EE_BASE) || ({1'b0, addrWord} >= addrEnd);

	assign access_error_flag = (paramIndex != 3'h1)
		|| !modeOk
		|| addrBad
		|| addrWord[0];
	// Lowest sectors up to the boundary are protected
	assign protErr = protEnable && (sector < {9'h000, protSectors});

endmodule : erase_check

/* flash_sequencer.sv */
// Flash command sequencer: sector erase, interrupts, stop, security.
// Assumes the array answers each request with a one-cycle done pulse.
`include "flash_seq_cfg.svh"

module flash_sequencer #(
	parameter logic [1:0]  EE_HI       = 2'h0,
	parameter logic [15:0] EE_BASE     = 16'h0400,
	parameter logic [15:0] EE_SIZE     = 16'h0400,
	parameter int          SECTOR_BITS = 2
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdData,
	// Mode and system
	input  wire logic        specialMode,
	input  wire logic        eraseAllowed,
	input  wire logic        stopReq,
	output logic             stopAck,
	output logic             secured,
	output logic             readBlocked,
	// Interrupt requests
	output logic             cmdIrq,
	output logic             errIrq,
	// Flash array
	input  wire logic [7:0]  secByte,
	input  wire logic [63:0] storedKeys,
	input  wire logic        eccSingleFault,
	input  wire logic        eccDoubleFault,
	output logic             eraseReq,
	output logic             verifyReq,
	output logic             verifyAllReq,
	output logic      [17:0] eraseAddr,
	input  wire logic        arrayDone,
	input  wire logic        arrayReadErr,
	input  wire logic        arrayDblErr,
	input  wire logic        arrayBlank
);

	key_check_if kc ();

	flash_seq_pkg::seq_state_e stateReg, stateNext;
	logic [7:0]  initCntReg, initCntNext;
	logic        ccifReg, ccifNext;
	logic        accerrReg, accerrNext;
	logic        fpviolReg, fpviolNext;
	logic        mgHiReg, mgHiNext;
	logic        mgLoReg, mgLoNext;
	logic        dfdReg, dfdNext;
	logic        sfdReg, sfdNext;
	logic        ccieReg, ccieNext;
	logic [1:0]  faultEnReg, faultEnNext;
	logic [7:0]  secReg, secNext;
	logic [7:0]  protReg, protNext;
	logic [2:0]  idxReg, idxNext;
	logic [15:0] paramReg [0:5];
	logic [15:0] paramNext [0:5];
	logic [15:0] rdDataReg, rdDataNext;
	logic        keyStart;
	logic        launch;
	logic        chkAcc;
	logic        chkProt;
	logic [7:0]  cmdCode;
	logic        wrStatus;
	logic        wrFault;

	erase_check #(
		.EE_HI       (EE_HI),
		.EE_BASE     (EE_BASE),
		.EE_SIZE     (EE_SIZE),
		.SECTOR_BITS (SECTOR_BITS)
	) u_check (
		.paramIndex  (idxReg),
		.cmdWord     (paramReg[0]),
		.addrWord    (paramReg[1]),
		.modeOk      (eraseAllowed),
		.protEnable  (protReg[`BIT_PROT_EN]),
		.protSectors (protReg[6:0]),
		.access_error_flag      (chkAcc),
		.protErr     (chkProt)
	);

	key_check u_key (
		.clk   (clk),
		.reset (reset),
		.kc    (kc)
	);

	assign kc.start     = keyStart;
	assign kc.presented = {paramReg[4], paramReg[3], paramReg[2], paramReg[1]};
	assign kc.stored    = storedKeys;

	assign cmdCode  = paramReg[0][15:8];
	assign wrStatus = regWr && (regAddr == `OFF_STATUS);
	assign wrFault  = regWr && (regAddr == `OFF_FAULT_STATUS);
	// Launch only from idle; launch writes to a busy sequencer are dropped
	assign launch   = wrStatus && regWrData[`BIT_CMD_COMPLETE_FLAG] && ccifReg
		&& (stateReg == flash_seq_pkg::ST_IDLE);

	// Register writes, flags and command sequencing
	always_comb begin
		// Clears come first so that a same-cycle set wins
		stateNext   = stateReg;
		initCntNext = initCntReg;
		ccifNext    = ccifReg;
		accerrNext  = accerrReg && !(wrStatus && regWrData[`BIT_ACCESS_ERROR_FLAG]);
		fpviolNext  = fpviolReg && !(wrStatus && regWrData[`BIT_PROTECTION_VIOLATION_FLAG]);
		mgHiNext    = mgHiReg;
		mgLoNext    = mgLoReg;
		dfdNext     = (dfdReg && !(wrFault && regWrData[`BIT_DOUBLE_FAULT_FLAG]))
			|| eccDoubleFault;
		sfdNext     = (sfdReg && !(wrFault && regWrData[`BIT_SINGLE_FAULT_FLAG]))
			|| eccSingleFault;
		ccieNext    = ccieReg;
		faultEnNext = faultEnReg;
		secNext     = secReg;
		protNext    = protReg;
		idxNext     = idxReg;
		keyStart    = 1'b0;
		paramNext   = paramReg;
		if (regWr) begin
			unique case (regAddr)
				`OFF_CONFIG: ccieNext = regWrData[`BIT_CMD_COMPLETE_IRQ_EN];
				`OFF_FAULT_CONFIG: faultEnNext = regWrData[1:0];
				`OFF_PROTECTION: protNext = regWrData[7:0];
				`OFF_PARAM_INDEX: idxNext = regWrData[2:0];
				`OFF_PARAM_WORD: begin
					if (ccifReg && idxReg < 3'h6) begin
						paramNext[idxReg] = regWrData;
					end
				end
				default: ;
			endcase
		end
		unique case (stateReg)
			flash_seq_pkg::ST_INIT: begin
				ccifNext    = 1'b0;
				initCntNext = initCntReg + 8'h01;
				if (initCntReg == `INIT_CYCLES) begin
					// Security byte only ever enters here
					secNext   = secByte;
					ccifNext  = 1'b1;
					stateNext = flash_seq_pkg::ST_IDLE;
				end
			end
			flash_seq_pkg::ST_IDLE: begin
				if (launch) begin
					mgHiNext = 1'b0;
					mgLoNext = 1'b0;
					if (cmdCode == `CMD_ERASE_SECTOR) begin
						if (chkAcc) begin
							accerrNext = 1'b1;
						end else if (chkProt) begin
							fpviolNext = 1'b1;
						end else begin
							ccifNext  = 1'b0;
							stateNext = flash_seq_pkg::ST_ERASE;
						end
					end else if (cmdCode == `CMD_VERIFY_KEY) begin
						if (idxReg != 3'h4 || kc.locked
							|| secReg[7:6] != `BACKDOOR_KEY_ENABLE_ENABLED) begin
							accerrNext = 1'b1;
						end else begin
							ccifNext  = 1'b0;
							keyStart  = 1'b1;
							stateNext = flash_seq_pkg::ST_KEY;
						end
					end else if (cmdCode == `CMD_VERIFY_ALL) begin
						if (idxReg != 3'h0) begin
							accerrNext = 1'b1;
						end else begin
							ccifNext  = 1'b0;
							stateNext = flash_seq_pkg::ST_VALL;
						end
					end else begin
						accerrNext = 1'b1;
					end
				end
			end
			flash_seq_pkg::ST_ERASE: begin
				if (arrayDone) begin
					stateNext = flash_seq_pkg::ST_VERIFY;
				end
			end
			flash_seq_pkg::ST_VERIFY: begin
				if (arrayDone) begin
					mgHiNext  = arrayReadErr || !arrayBlank;
					mgLoNext  = arrayDblErr || !arrayBlank;
					ccifNext  = 1'b1;
					stateNext = flash_seq_pkg::ST_IDLE;
				end
			end
			flash_seq_pkg::ST_KEY: begin
				if (kc.done) begin
					// Only the register copy changes, never the stored byte
					if (kc.match) begin
						secNext[1:0] = `SEC_UNSECURED;
					end else begin
						accerrNext = 1'b1;
					end
					ccifNext  = 1'b1;
					stateNext = flash_seq_pkg::ST_IDLE;
				end
			end
			flash_seq_pkg::ST_VALL: begin
				if (arrayDone) begin
					mgHiNext = arrayReadErr || !arrayBlank;
					mgLoNext = arrayDblErr || !arrayBlank;
					if (specialMode && arrayBlank) begin
						secNext[1:0] = `SEC_UNSECURED;
					end
					ccifNext  = 1'b1;
					stateNext = flash_seq_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// Synchronous reset drops any request mid-command
	always_ff @(posedge clk) begin
		if (reset) begin
			stateReg   <= flash_seq_pkg::ST_INIT;
			initCntReg <= 8'h00;
			ccifReg    <= 1'b0;
			accerrReg  <= 1'b0;
			fpviolReg  <= 1'b0;
			mgHiReg    <= 1'b0;
			mgLoReg    <= 1'b0;
			dfdReg     <= 1'b0;
			sfdReg     <= 1'b0;
			ccieReg    <= 1'b0;
			faultEnReg <= 2'h0;
			secReg     <= `SEC_RESET;
			protReg    <= `PROT_RESET;
			idxReg     <= 3'h0;
			paramReg   <= '{default: 16'h0000};
			rdDataReg  <= 16'h0000;
		end else begin
			stateReg   <= stateNext;
			initCntReg <= initCntNext;
			ccifReg    <= ccifNext;
			accerrReg  <= accerrNext;
			fpviolReg  <= fpviolNext;
			mgHiReg    <= mgHiNext;
			mgLoReg    <= mgLoNext;
			dfdReg     <= dfdNext;
			sfdReg     <= sfdNext;
			ccieReg    <= ccieNext;
			faultEnReg <= faultEnNext;
			secReg     <= secNext;
			protReg    <= protNext;
			idxReg     <= idxNext;
			paramReg   <= paramNext;
			rdDataReg  <= rdDataNext;
		end
	end

	// Read data, valid only the cycle after the strobe
	always_comb begin
		rdDataNext = 16'h0000;
		if (regRd) begin
			unique case (regAddr)
				`OFF_CONFIG: rdDataNext = {8'h00, ccieReg, 7'h00};
				`OFF_FAULT_CONFIG: rdDataNext = {14'h0000, faultEnReg};
				`OFF_STATUS: rdDataNext = {8'h00, ccifReg, 1'b0, accerrReg,
					fpviolReg, 2'h0, mgHiReg, mgLoReg};
				`OFF_FAULT_STATUS: rdDataNext = {14'h0000, dfdReg, sfdReg};
				`OFF_SECURITY: rdDataNext = {8'h00, secReg};
				`OFF_PROTECTION: rdDataNext = {8'h00, protReg};
				`OFF_PARAM_INDEX: rdDataNext = {13'h0000, idxReg};
				`OFF_PARAM_WORD: begin
					if (idxReg < 3'h6) begin
						rdDataNext = paramReg[idxReg];
					end
				end
				default: rdDataNext = 16'h0000;
			endcase
		end
	end

	assign regRdData = rdDataReg;
	// Levels, no latching: wake from wait relies on cmdIrq
	assign cmdIrq = ccifReg && ccieReg;
	assign errIrq = (dfdReg && faultEnReg[`BIT_DOUBLE_FAULT_IRQ_EN])
		|| (sfdReg && faultEnReg[`BIT_SINGLE_FAULT_IRQ_EN]);
	// Stop granted only with no command in flight
	assign stopAck     = stopReq && ccifReg;
	assign secured     = (secReg[1:0] != `SEC_UNSECURED);
	assign readBlocked = kc.busy;
	assign eraseReq     = (stateReg == flash_seq_pkg::ST_ERASE);
	assign verifyReq    = (stateReg == flash_seq_pkg::ST_VERIFY);
	assign verifyAllReq = (stateReg == flash_seq_pkg::ST_VALL);
	assign eraseAddr    = {paramReg[0][1:0], paramReg[1][15:1], 1'b0};

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_LAUNCH_ERASE: assert property (
		launch && cmdCode == `CMD_ERASE_SECTOR && !chkAcc && !chkProt
		|=> eraseReq && !ccifReg
	) else $error("Sector erase did not start");
	AST_INDEX_ERROR: assert property (
		launch && cmdCode == `CMD_ERASE_SECTOR && idxReg != 3'h1
		|=> accerrReg && ccifReg && !eraseReq [*2]
	) else $error("Bad index erase not refused");
	AST_PROTECT: assert property (
		launch && cmdCode == `CMD_ERASE_SECTOR && !chkAcc && chkProt
		|=> fpviolReg && !eraseReq
	) else $error("Protected sector not refused");
	AST_MARGIN: assert property (
		verifyReq && arrayDone && arrayReadErr
		|=> mgHiReg && ccifReg && $rose(ccifReg)
	) else $error("Verify read error not flagged");
	AST_CMD_IRQ: assert property (
		$rose(ccifReg) && ccieReg |-> cmdIrq
	) else $error("Command interrupt missing");
	AST_ERR_IRQ: assert property (
		$rose(dfdReg) && faultEnReg[`BIT_DOUBLE_FAULT_IRQ_EN] |-> errIrq
	) else $error("Double fault interrupt missing");
	AST_STOP: assert property (
		eraseReq || verifyReq |-> !stopAck
	) else $error("Stop granted during command");
	AST_INIT_HOLD: assert property (
		stateReg == flash_seq_pkg::ST_INIT |-> !ccifReg ##1
		(stateReg == flash_seq_pkg::ST_INIT || ccifReg)
	) else $error("Complete flag high during init");
	AST_SEC_STABLE: assert property (
		stateReg == flash_seq_pkg::ST_ERASE ##1
		stateReg == flash_seq_pkg::ST_ERASE |-> $stable(secReg)
	) else $error("Security changed during erase");
	AST_READ_BLOCK: assert property (
		keyStart |=> readBlocked [*4] ##1 kc.done
	) else $error("Reads not blocked during key check");

endmodule : flash_sequencer

/* flash_array_model.sv */
// Flash array stand-in: answers each request after a set latency.
// Assumes requests are levels held until the done pulse.
module flash_array_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Requests
	input  wire logic eraseReq,
	input  wire logic verifyReq,
	input  wire logic verifyAllReq,
	// Behaviour chosen by the bench
	input  var  int   latency,
	input  wire logic readErr,
	input  wire logic dblErr,
	input  wire logic blank,
	// Answer
	output logic      arrayDone,
	output logic      arrayReadErr,
	output logic      arrayDblErr,
	output logic      arrayBlank
);
	int   waitCnt = 0;
	logic toggle  = 1'h0;

	// Results churn outside done, so a stale value never passes
	assign arrayReadErr = arrayDone ? readErr : toggle;
	assign arrayDblErr  = arrayDone ? dblErr : ~toggle;
	assign arrayBlank   = arrayDone ? blank : toggle;

	initial arrayDone = 1'h0;
	always @(posedge clk) begin
		toggle    <= ~toggle;
		arrayDone <= 1'h0;
		if (reset || arrayDone || !(eraseReq || verifyReq || verifyAllReq))
			waitCnt <= 0;
		else if (waitCnt >= latency) begin
			arrayDone <= 1'h1;
			waitCnt   <= 0;
		end else
			waitCnt <= waitCnt + 1;
	end
endmodule : flash_array_model

/* tb_flash_sequencer.sv */
// Self-checking bench of the flash sequencer against an array stand-in.
// Assumes the sequencer's default geometry parameters.
`include "flash_seq_cfg.svh"
module tb_flash_sequencer;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk, regWr = 1'h0, regRd = 1'h0, stopAck, secured;
	logic        reset = 1'h1, specialMode = 1'h0, eraseAllowed = 1'h1;
	logic        stopReq = 1'h0, eccSingleFault = 1'h0, eccDoubleFault = 1'h0;
	logic        cmdIrq, errIrq, readBlocked, eraseReq, verifyReq;
	logic        verifyAllReq, arrayDone, arrayReadErr, arrayDblErr;
	logic        arrayBlank, rdErr = 1'h0, dblErr = 1'h0, blank = 1'h1;
	logic        acc, pv, ran, en, sawErase, sawVerify, sawBlock, sawAll;
	logic        stopBad = 1'h0;
	logic [1:0]  hi;
	logic [2:0]  idx;
	logic [3:0]  regAddr = 4'h0;
	logic [15:0] regWrData = 16'h0000, regRdData, rdData, a;
	logic [15:0] pw [5];
	logic [7:0]  secByte = 8'hFF, prot;
	logic [63:0] storedKeys = 64'h4444_3333_2222_1111;
	logic [17:0] eraseAddr, lastAddr;
	int          latency = 2, nErrors = 0, testsRun = 0, cycles = 0, i;

	flash_sequencer dut (
		.clk, .reset, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
		.specialMode, .eraseAllowed, .stopReq, .stopAck, .secured,
		.readBlocked, .cmdIrq, .errIrq, .secByte, .storedKeys,
		.eccSingleFault, .eccDoubleFault, .eraseReq, .verifyReq,
		.verifyAllReq, .eraseAddr, .arrayDone, .arrayReadErr,
		.arrayDblErr, .arrayBlank
	);
	flash_array_model array (
		.clk, .reset, .eraseReq, .verifyReq, .verifyAllReq, .latency,
		.readErr(rdErr), .dblErr, .blank, .arrayDone, .arrayReadErr,
		.arrayDblErr, .arrayBlank
	);

	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	// Watched at the falling edge, where all outputs have settled
	always @(negedge clk) begin
		cycles++;
		if (eraseReq)
			lastAddr = eraseAddr;
		sawErase  = sawErase | eraseReq;
		sawVerify = sawVerify | verifyReq;
		sawBlock  = sawBlock | readBlocked;
		sawAll    = sawAll | verifyAllReq;
		stopBad   = stopBad | (stopAck & (eraseReq | verifyReq));
		if (cycles >= 20000) begin
			nErrors++;
			conclude();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			nErrors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task wr(input logic [3:0] ad, input logic [15:0] d);
		@(posedge clk);
		regAddr   <= ad;
		regWrData <= d;
		regWr     <= 1'h1;
		@(posedge clk);
		regWr <= 1'h0;
	endtask : wr

	task rd(input logic [3:0] ad);
		@(posedge clk);
		regAddr <= ad;
		regRd   <= 1'h1;
		@(posedge clk);
		regRd <= 1'h0;
		@(negedge clk);
		rdData = regRdData;
	endtask : rd

	task cmd(input int n, input logic [2:0] ix, input logic wt);
		int k;
		wr(`OFF_STATUS, 16'h0030);
		for (k = 0; k < n; k++) begin
			wr(`OFF_PARAM_INDEX, 16'(k));
			wr(`OFF_PARAM_WORD, pw[k]);
		end
		wr(`OFF_PARAM_INDEX, {13'h0000, ix});
		sawErase  = 1'h0;
		sawVerify = 1'h0;
		sawBlock  = 1'h0;
		sawAll    = 1'h0;
		wr(`OFF_STATUS, 16'h0080);
		for (k = 0; wt && k < 200; k++) begin
			rd(`OFF_STATUS);
			if (rdData[7] === 1'h1)
				break;
		end
		check(k < 200, 1'h1);
	endtask : cmd

	task doReset(input logic [7:0] sb);
		@(posedge clk);
		secByte <= sb;
		reset   <= 1'h1;
		repeat (15) @(posedge clk);
		reset <= 1'h0;
		rd(`OFF_STATUS);
		check(rdData[7], 1'h0);
		repeat (20) @(posedge clk);
		rd(`OFF_STATUS);
		check(rdData[7], 1'h1);
		rd(`OFF_SECURITY);
		check(rdData, {8'h00, sb});
		check(secured, sb[1:0] != 2'h2);
	endtask : doReset

	task keyCmd(input logic [63:0] k, input logic expAcc, input logic blk);
		pw[0] = 16'h0C00;
		pw[1] = k[15:0];
		pw[2] = k[31:16];
		pw[3] = k[47:32];
		pw[4] = k[63:48];
		cmd(5, 3'h4, 1'h1);
		check(rdData[5], expAcc);
		check(secured, expAcc);
		check(sawBlock, blk);
	endtask : keyCmd

	task conclude();
		$display("comparisons %0d, mismatches %0d", testsRun, nErrors);
		if (nErrors == 0 && testsRun > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	initial begin
		void'($urandom(32'hF178));
		doReset(8'hFF);
		rd(`OFF_PROTECTION);
		check(rdData, 16'h0000);
		rd(4'hF);
		check(rdData, 16'h0000);
		$display("test reset finished");
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			hi = ($urandom % 4 == 0) ? 2'($urandom) : 2'h0;
			a = ($urandom % 2) ? 16'h0400 + 16'($urandom % 40)
				: 16'($urandom_range(32'h03F0, 32'h0820));
			idx = ($urandom % 6 == 0) ? 3'($urandom) : 3'h1;
			prot = {1'($urandom), 7'($urandom % 8)};
			en = 1'($urandom);
			eraseAllowed <= ($urandom % 6 != 0);
			stopReq <= 1'($urandom);
			rdErr = 1'($urandom);
			dblErr <= rdErr & 1'($urandom);
			latency <= $urandom % 5;
			wr(`OFF_PROTECTION, {8'h00, prot});
			wr(`OFF_CONFIG, {8'h00, en, 7'h00});
			pw[0] = {8'h12, 6'h00, hi};
			pw[1] = a;
			cmd(2, idx, 1'h1);
			acc = idx != 3'h1 || !eraseAllowed || hi != 2'h0 || a[0]
				|| a < 16'h0400 || a >= 16'h0800;
			pv = !acc && prot[7] && ((a - 16'h0400) >> 2) < prot[6:0];
			ran = !acc && !pv;
			check(rdData[5], acc);
			check(rdData[4], pv);
			check(rdData[1:0], ran ? {rdErr, dblErr} : 2'h0);
			check({sawErase, sawVerify}, {ran, ran});
			if (ran)
				check(lastAddr, {hi, a[15:1], 1'h0});
			check(cmdIrq, en);
			check(stopAck, stopReq);
		end
		check(stopBad, 1'h0);
		wr(`OFF_CONFIG, 16'h0000);
		@(negedge clk);
		check(cmdIrq, 1'h0);
		$display("test erase finished");
		for (i = 0; i < 16; i++) begin
			wr(`OFF_FAULT_CONFIG, {14'h0000, 2'(i)});
			eccDoubleFault <= i[3];
			eccSingleFault <= i[2];
			@(posedge clk);
			eccDoubleFault <= 1'h0;
			eccSingleFault <= 1'h0;
			@(negedge clk);
			check(errIrq, (i[3] & i[1]) | (i[2] & i[0]));
			wr(`OFF_FAULT_STATUS, 16'h0003);
			@(negedge clk);
			check(errIrq, 1'h0);
		end
		$display("test faults finished");
		@(posedge clk);
		eraseAllowed <= 1'h1;
		latency <= 60;
		wr(`OFF_PROTECTION, 16'h0000);
		pw[0] = 16'h1200;
		pw[1] = 16'h0500;
		cmd(2, 3'h1, 1'h0);
		repeat (4) @(posedge clk);
		@(negedge clk);
		check(eraseReq, 1'h1);
		@(posedge clk);
		reset <= 1'h1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check(eraseReq, 1'h0);
		latency <= 2;
		$display("test abort finished");
		doReset(8'h80);
		keyCmd(64'h4444_3333_2222_1112, 1'h1, 1'h1);
		keyCmd(storedKeys, 1'h1, 1'h0);
		doReset(8'h80);
		keyCmd(storedKeys, 1'h0, 1'h1);
		rd(`OFF_SECURITY);
		check(rdData, 16'h0082);
		rd(`OFF_PROTECTION);
		check(rdData, 16'h0000);
		@(posedge clk);
		secByte <= 8'hFF;
		repeat (8) @(posedge clk);
		@(negedge clk);
		check(secured, 1'h0);
		@(posedge clk);
		storedKeys <= 64'h4444_0000_2222_1111;
		doReset(8'h80);
		keyCmd(64'h4444_0000_2222_1111, 1'h1, 1'h1);
		$display("test keys finished");
		for (i = 0; i < 3; i++) begin
			@(posedge clk);
			specialMode <= i != 0;
			blank <= i != 2;
			doReset(8'hFF);
			pw[0] = 16'h0100;
			cmd(1, 3'h0, 1'h1);
			check(secured, i != 1);
			check(sawAll, 1'h1);
		end
		$display("test verify all finished");
		conclude();
	end
endmodule : tb_flash_sequencer
